// ---- hw/sdpsd_params.svh ----
// Constants for the power-state and DLL-off block
`ifndef SDPSD_PARAMS_SVH
`define SDPSD_PARAMS_SVH
`define SDPSD_CAS_LAT_OFF 5'h0a
`define SDPSD_CAS_WR_LAT_OFF 5'h09
`define SDPSD_BURST_CYC 4'h4
`define SDPSD_PRE_CYC 4'h3
`define SDPSD_REF_CYC 4'h8
`define SDPSD_MR1_ADDR 2'h1
`define SDPSD_DLL_BIT 0
`endif

// ---- hw/sdpsd_pkg.sv ----
// Types for the power-state and DLL-off block
package sdpsd_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ACTIVE, ST_READ, ST_WRITE, ST_PRECH, ST_REFRESH,
		ST_PD_PRE, ST_PD_ACT, ST_SELF_REF
	} sdpsd_state_e;
	typedef enum logic [3:0] {
		C_DESEL, C_NOP, C_MRS, C_REF, C_PRE, C_PREA, C_ACT, C_WR, C_RD, C_OTHER
	} sdpsd_cmd_e;
	typedef struct packed {
		logic cs_n;
		logic act_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} sdpsd_pins_s;
endpackage

// ---- hw/sdpsd_decode.sv ----
// Command decoder from pin levels
`timescale 1ns/1ns
module sdpsd_decode (
	input wire sdpsd_pkg::sdpsd_pins_s pins_in,
	input wire logic a10_in,
	output sdpsd_pkg::sdpsd_cmd_e cmd_out
);
	wire logic [3:0] code;
	assign code = {pins_in.act_n, pins_in.ras_n, pins_in.cas_n, pins_in.we_n};
	// Select high always means chip_cmd_a, whatever the other pins show
	assign cmd_out = pins_in.cs_n ? sdpsd_pkg::C_DESEL :
		!pins_in.act_n ? sdpsd_pkg::C_ACT :
		(code == 4'hf) ? sdpsd_pkg::C_NOP :
		(code == 4'h8) ? sdpsd_pkg::C_MRS :
		(code == 4'h9) ? sdpsd_pkg::C_REF :
		(code == 4'ha) ? (a10_in ? sdpsd_pkg::C_PREA : sdpsd_pkg::C_PRE) :
		(code == 4'hc) ? sdpsd_pkg::C_WR :
		(code == 4'hd) ? sdpsd_pkg::C_RD : sdpsd_pkg::C_OTHER;
endmodule

// ---- hw/sdpsd_core.sv ----
// Power-state tracker with DLL-off control and read strobe timing
`timescale 1ns/1ns
`include "sdpsd_params.svh"
module sdpsd_core #(
	parameter int BANKS = 16
) (
	input wire logic CORE_CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic CKE_IN,
	input wire logic CS_N_IN,
	input wire logic ACT_N_IN,
	input wire logic RAS_N_IN,
	input wire logic CAS_N_IN,
	input wire logic WE_N_IN,
	input wire logic ON_DIE_TERMINATION_IN,
	input wire logic [1:0] BG_IN,
	input wire logic [1:0] BA_IN,
	input wire logic [13:0] ADDR_IN,
	input wire logic [4:0] ADDITIVE_LATENCY_IN,
	output logic [3:0] STATE_OUT,
	output logic DLL_ENABLED_OUT,
	output logic TERM_ACTIVE_OUT,
	output logic READ_STROBE_START_OUT,
	output logic [4:0] CAS_LATENCY_OUT,
	output logic [4:0] CAS_WRITE_LATENCY_OUT
);
	// ----------------------------------------
	// Reset and pin synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync_reg;
	wire logic rst_n;
	assign rst_n = rst_sync_reg[1];
	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) rst_sync_reg <= 2'h0;
		else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	// Pins come from the link, so two stages before use
	logic [21:0] pin_s1_reg;
	logic [21:0] pin_s2_reg;
	always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			// Idle pin levels: enable high, chip_cmd_a, termination off
			pin_s1_reg <= 22'h3f0000;
			pin_s2_reg <= 22'h3f0000;
		end else begin
			pin_s1_reg <= {CKE_IN, CS_N_IN, ACT_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN,
				ON_DIE_TERMINATION_IN, BG_IN, BA_IN, ADDR_IN[10:0]};
			pin_s2_reg <= pin_s1_reg;
		end
	end
	wire logic cke;
	wire logic on_die_termination;
	wire logic [3:0] bank;
	wire logic [12:0] addr;
	sdpsd_pkg::sdpsd_pins_s pins;
	assign cke = pin_s2_reg[21];
	assign pins = pin_s2_reg[20:16];
	assign on_die_termination = pin_s2_reg[15];
	assign bank = pin_s2_reg[14:11];
	// Only A0 and A10 matter here, upper address bits are not kept
	assign addr = {2'h0, pin_s2_reg[10:0]};

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	sdpsd_pkg::sdpsd_cmd_e cmd;
	sdpsd_decode u_dec (
		.pins_in(pins),
		.a10_in(pin_s2_reg[10]),
		.cmd_out(cmd)
	);
	logic cke_prev_reg;
	always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
		if (!rst_n) cke_prev_reg <= 1'b1;
		else cke_prev_reg <= cke;
	end
	wire logic cke_fall;
	wire logic cke_rise;
	wire logic cke_low;
	assign cke_fall = cke_prev_reg && !cke;
	assign cke_rise = !cke_prev_reg && cke;
	assign cke_low = !cke_prev_reg && !cke;
	wire logic is_desel;
	assign is_desel = (cmd == sdpsd_pkg::C_DESEL);

	// ----------------------------------------
	// Bank tracking and operation timer
	// ----------------------------------------
	logic [BANKS-1:0] open_reg;
	logic [BANKS-1:0] open_next;
	logic [3:0] op_cnt_reg;
	wire logic all_closed;
	wire logic busy;
	wire logic low_power;
	sdpsd_pkg::sdpsd_state_e st_reg;
	sdpsd_pkg::sdpsd_state_e st_next;
	assign low_power = (st_reg == sdpsd_pkg::ST_PD_PRE) || (st_reg == sdpsd_pkg::ST_PD_ACT)
		|| (st_reg == sdpsd_pkg::ST_SELF_REF);
	assign busy = (op_cnt_reg != 4'h0);
	// Commands only register when powered up and enabled
	wire logic take;
	assign take = !low_power && cke_prev_reg && cke && !is_desel;
	always_comb begin
		open_next = open_reg;
		if (take && cmd == sdpsd_pkg::C_ACT) open_next[bank] = 1'b1;
		if (take && cmd == sdpsd_pkg::C_PRE) open_next[bank] = 1'b0;
		if (take && cmd == sdpsd_pkg::C_PREA) open_next = '0;
	end
	assign all_closed = (open_next == '0);
	always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
		if (!rst_n) open_reg <= '0;
		else open_reg <= open_next;
	end
	// Running operations count down regardless of chip_cmd_a
	always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
		if (!rst_n) op_cnt_reg <= 4'h0;
		else if (take && (cmd == sdpsd_pkg::C_RD || cmd == sdpsd_pkg::C_WR))
			op_cnt_reg <= `SDPSD_BURST_CYC;
		else if (take && (cmd == sdpsd_pkg::C_PRE || cmd == sdpsd_pkg::C_PREA))
			op_cnt_reg <= `SDPSD_PRE_CYC;
		else if (take && cmd == sdpsd_pkg::C_REF) op_cnt_reg <= `SDPSD_REF_CYC;
		else if (busy && !(st_reg == sdpsd_pkg::ST_PD_PRE) && !(st_reg == sdpsd_pkg::ST_PD_ACT))
			op_cnt_reg <= op_cnt_reg - 4'h1;
	end
	// Pending power-down kind chosen when the operation ends
	logic pd_pend_reg;
	always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
		if (!rst_n) pd_pend_reg <= 1'b0;
		else if (cke) pd_pend_reg <= 1'b0;
		else if (cke_fall && busy) pd_pend_reg <= 1'b1;
		else if (!busy) pd_pend_reg <= 1'b0;
	end

	// ----------------------------------------
	// State machine
	// ----------------------------------------
	wire logic pd_kind_pre;
	assign pd_kind_pre = all_closed;
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			sdpsd_pkg::ST_PD_PRE, sdpsd_pkg::ST_PD_ACT: begin
				// No refresh here; exit needs rising enable with chip_cmd_a
				if (cke_rise && is_desel) st_next = open_reg == '0 ?
					sdpsd_pkg::ST_IDLE : sdpsd_pkg::ST_ACTIVE;
			end
			sdpsd_pkg::ST_SELF_REF: begin
				if (cke_rise && is_desel) st_next = sdpsd_pkg::ST_IDLE;
			end
			sdpsd_pkg::ST_IDLE: begin
				if (cke_fall && cmd == sdpsd_pkg::C_REF && open_reg == '0 && !busy)
					st_next = sdpsd_pkg::ST_SELF_REF;
				else if (cke_fall && is_desel) st_next = sdpsd_pkg::ST_PD_PRE;
				else if (take && cmd == sdpsd_pkg::C_ACT) st_next = sdpsd_pkg::ST_ACTIVE;
				else if (take && cmd == sdpsd_pkg::C_REF) st_next = sdpsd_pkg::ST_REFRESH;
			end
			sdpsd_pkg::ST_REFRESH: begin
				if (cke_fall && is_desel) st_next = sdpsd_pkg::ST_PD_PRE;
				else if (!busy) st_next = sdpsd_pkg::ST_IDLE;
			end
			sdpsd_pkg::ST_ACTIVE, sdpsd_pkg::ST_READ, sdpsd_pkg::ST_WRITE,
			sdpsd_pkg::ST_PRECH: begin
				if ((cke_fall && is_desel && !busy) || (pd_pend_reg && !busy) ||
						(cke_low && !busy && st_reg != sdpsd_pkg::ST_ACTIVE))
					st_next = pd_kind_pre ? sdpsd_pkg::ST_PD_PRE : sdpsd_pkg::ST_PD_ACT;
				else if (cke_fall && is_desel) st_next = st_reg;
				else if (take && cmd == sdpsd_pkg::C_RD) st_next = sdpsd_pkg::ST_READ;
				else if (take && cmd == sdpsd_pkg::C_WR) st_next = sdpsd_pkg::ST_WRITE;
				else if (take && (cmd == sdpsd_pkg::C_PRE || cmd == sdpsd_pkg::C_PREA))
					st_next = sdpsd_pkg::ST_PRECH;
				else if (take && cmd == sdpsd_pkg::C_ACT) st_next = sdpsd_pkg::ST_ACTIVE;
				else if (!busy && !take)
					st_next = open_reg == '0 ? sdpsd_pkg::ST_IDLE : sdpsd_pkg::ST_ACTIVE;
			end
			default: st_next = sdpsd_pkg::ST_IDLE;
		endcase
	end
	always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
		if (!rst_n) st_reg <= sdpsd_pkg::ST_IDLE;
		else st_reg <= st_next;
	end
	assign STATE_OUT = st_reg;

	// ----------------------------------------
	// DLL control and latencies
	// ----------------------------------------
	logic dll_en_reg;
	wire logic mr1_write;
	assign mr1_write = take && cmd == sdpsd_pkg::C_MRS && bank[1:0] == `SDPSD_MR1_ADDR;
	always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
		if (!rst_n) dll_en_reg <= 1'b1;
		else if (mr1_write) dll_en_reg <= addr[`SDPSD_DLL_BIT];
	end
	assign DLL_ENABLED_OUT = dll_en_reg;
	// One fixed latency pair when the DLL is off
	always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			CAS_LATENCY_OUT <= `SDPSD_CAS_LAT_OFF;
			CAS_WRITE_LATENCY_OUT <= `SDPSD_CAS_WR_LAT_OFF;
		end else begin
			CAS_LATENCY_OUT <= `SDPSD_CAS_LAT_OFF;
			CAS_WRITE_LATENCY_OUT <= `SDPSD_CAS_WR_LAT_OFF;
		end
	end
	// Termination never steers the state; cut off in self refresh
	always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
		if (!rst_n) TERM_ACTIVE_OUT <= 1'b0;
		else TERM_ACTIVE_OUT <= on_die_termination && (st_next != sdpsd_pkg::ST_SELF_REF);
	end

	// ----------------------------------------
	// Read strobe start counter
	// ----------------------------------------
	// Strobe to data is untouched; only the start cycle moves
	logic [5:0] rd_cnt_reg;
	wire logic [5:0] rd_delay;
	assign rd_delay = dll_en_reg ? 6'(ADDITIVE_LATENCY_IN) + 6'(`SDPSD_CAS_LAT_OFF)
		: 6'(ADDITIVE_LATENCY_IN) + 6'(`SDPSD_CAS_LAT_OFF) - 6'h1;
	always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
		if (!rst_n) rd_cnt_reg <= 6'h0;
		else if (take && cmd == sdpsd_pkg::C_RD) rd_cnt_reg <= rd_delay;
		else if (rd_cnt_reg != 6'h0) rd_cnt_reg <= rd_cnt_reg - 6'h1;
	end
	always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
		if (!rst_n) READ_STROBE_START_OUT <= 1'b0;
		else READ_STROBE_START_OUT <= (rd_cnt_reg == 6'h2);
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence sr_entry_s;
		cke_fall && cmd == sdpsd_pkg::C_REF && st_reg == sdpsd_pkg::ST_IDLE &&
			open_reg == '0 && !busy;
	endsequence
	sr_enter_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
		sr_entry_s |=> st_reg == sdpsd_pkg::ST_SELF_REF)
		else $error("self refresh not entered");
	sr_legal_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
		st_reg != sdpsd_pkg::ST_SELF_REF ##1 st_reg == sdpsd_pkg::ST_SELF_REF |->
		$past(st_reg) == sdpsd_pkg::ST_IDLE)
		else $error("illegal self refresh entry");
	lp_hold_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
		low_power && !cke |=> st_reg == $past(st_reg))
		else $error("low power state left without enable");
	lp_exit_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
		low_power && cke_rise && is_desel |=> !low_power)
		else $error("low power exit missed");
	lp_ignore_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
		low_power && !is_desel |=> $stable(open_reg) && $stable(dll_en_reg))
		else $error("command taken in low power");
	pd_norefresh_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
		(st_reg == sdpsd_pkg::ST_PD_PRE || st_reg == sdpsd_pkg::ST_PD_ACT) |=>
		st_reg != sdpsd_pkg::ST_REFRESH)
		else $error("refresh in power down");
	term_sr_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
		st_reg == sdpsd_pkg::ST_SELF_REF ##1 st_reg == sdpsd_pkg::ST_SELF_REF
		|-> !TERM_ACTIVE_OUT)
		else $error("termination active in self refresh");
	dll_off_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
		mr1_write && !addr[0] |=> !dll_en_reg)
		else $error("dll not disabled");
	desel_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
		is_desel |=> open_reg == $past(open_reg))
		else $error("chip_cmd_a changed banks");
	rd_strobe_a: assert property (@(posedge CORE_CLK_IN) disable iff (!rst_n)
		take && cmd == sdpsd_pkg::C_RD && !dll_en_reg && ADDITIVE_LATENCY_IN == 5'h0
		|-> ##9 READ_STROBE_START_OUT)
		else $error("dll off strobe start wrong");
endmodule

// ---- bench/sdpsd_ctrl_model.sv ----
// Memory controller model driving the command side of the block
`timescale 1ns/1ns
module sdpsd_ctrl_model #(
	parameter int CKE_MIN_CYC = 4,
	parameter int XS_CYC = 8
) (
	input wire logic clk_in,
	output logic cke_out,
	output sdpsd_pkg::sdpsd_pins_s pins_out,
	output logic odt_out,
	output logic [1:0] bg_out,
	output logic [1:0] ba_out,
	output logic [13:0] addr_out
);
	// ------------------------------------------------
	// Drivers
	// ------------------------------------------------
	initial begin
		cke_out = 1'b1;
		pins_out = 5'h1f;
		odt_out = 1'b0;
		bg_out = 2'h0;
		ba_out = 2'h0;
		addr_out = 14'h0000;
	end
	// Chip_cmd_a pattern flips every cycle so stale pins never look valid
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk_in);
			#1;
			pins_out <= {1'b1, ~pins_out[3:0]};
			addr_out <= ~addr_out;
			bg_out <= ~bg_out;
			ba_out <= ~ba_out;
		end
	endtask
	// One command edge, then chip_cmd_a; DLL bit writes come from the bench
	task automatic cmd(input logic [3:0] p, input logic [3:0] bank, input logic [13:0] a);
		@(posedge clk_in);
		#1;
		pins_out <= {1'b0, p};
		bg_out <= bank[3:2];
		ba_out <= bank[1:0];
		addr_out <= a;
		idle(1);
	endtask
	task automatic set_cke(input logic lvl, input logic cs_n, input logic [3:0] p);
		@(posedge clk_in);
		#1;
		cke_out <= lvl;
		pins_out <= {cs_n, p};
		idle(CKE_MIN_CYC);
		if (lvl) begin
			idle(XS_CYC);
		end
	endtask
	task automatic on_die_termination(input logic lvl);
		@(posedge clk_in);
		#1;
		odt_out <= lvl;
	endtask
endmodule

// ---- bench/test_sdpsd_core.sv ----
// Self-checking bench for the power-state tracker
`timescale 1ns/1ns
module test_sdpsd_core;
	logic clk;
	logic rst_n;
	logic cke;
	logic on_die_termination;
	sdpsd_pkg::sdpsd_pins_s pins;
	logic [1:0] bg;
	logic [1:0] ba;
	logic [13:0] addr;
	logic [4:0] al;
	logic [3:0] state;
	logic dll;
	logic term;
	logic rss;
	logic [4:0] cl;
	logic [4:0] cas_write_latency;
	logic [4:0] n_on;
	logic [4:0] n_off;
	int n_mismatch;
	int checks_done;
	// ------------------------------------------------
	// Clock, instances, checks
	// ------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	sdpsd_ctrl_model u_ctl (.clk_in(clk), .cke_out(cke), .pins_out(pins), .odt_out(on_die_termination),
		.bg_out(bg), .ba_out(ba), .addr_out(addr));
	sdpsd_core i_dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .CKE_IN(cke),
		.CS_N_IN(pins.cs_n), .ACT_N_IN(pins.act_n), .RAS_N_IN(pins.ras_n),
		.CAS_N_IN(pins.cas_n), .WE_N_IN(pins.we_n), .ON_DIE_TERMINATION_IN(on_die_termination),
		.BG_IN(bg), .BA_IN(ba), .ADDR_IN(addr), .ADDITIVE_LATENCY_IN(al),
		.STATE_OUT(state), .DLL_ENABLED_OUT(dll), .TERM_ACTIVE_OUT(term),
		.READ_STROBE_START_OUT(rss), .CAS_LATENCY_OUT(cl), .CAS_WRITE_LATENCY_OUT(cas_write_latency));
	task automatic end_sim();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cmp_val(input logic [4:0] got, input logic [4:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_state(input sdpsd_pkg::sdpsd_state_e exp);
		cmp_val({1'b0, state}, {1'b0, exp});
	endtask
	// Latency counted from the read edge; only differences are judged
	task automatic rd_lat(output logic [4:0] n);
		n = 5'h0;
		u_ctl.cmd(4'hd, 4'h4, 14'h0000);
		while (rss !== 1'b1 && n < 5'h1f) begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		#1;
		cmp_val({4'h0, rss}, 5'h00);
	endtask
	initial begin
		#20000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		n_mismatch = 0;
		checks_done = 0;
		rst_n = 1'b0;
		al = 5'h02;
		repeat (5) @(posedge clk);
		#1;
		rst_n = 1'b1;
		u_ctl.idle(6);
		cmp_state(sdpsd_pkg::ST_IDLE);
		cmp_val({4'h0, dll}, 5'h01);
		cmp_val(cl, 5'h0a);
		cmp_val(cas_write_latency, 5'h09);
		cmp_val({4'h0, term}, 5'h00);
		u_ctl.cmd(4'h7, 4'h4, 14'h0000);
		u_ctl.idle(3);
		cmp_state(sdpsd_pkg::ST_ACTIVE);
		rd_lat(n_on);
		u_ctl.idle(4);
		u_ctl.set_cke(1'b0, 1'b1, 4'h0);
		cmp_state(sdpsd_pkg::ST_PD_ACT);
		u_ctl.cmd(4'h9, 4'h0, 14'h0000);
		u_ctl.idle(12);
		cmp_state(sdpsd_pkg::ST_PD_ACT);
		u_ctl.set_cke(1'b1, 1'b1, 4'h0);
		cmp_state(sdpsd_pkg::ST_ACTIVE);
		u_ctl.cmd(4'ha, 4'h4, 14'h0400);
		u_ctl.idle(8);
		cmp_state(sdpsd_pkg::ST_IDLE);
		u_ctl.cmd(4'h8, 4'h1, 14'h0000);
		u_ctl.idle(4);
		cmp_val({4'h0, dll}, 5'h00);
		cmp_val(cl, 5'h0a);
		// Zero additive latency arms the strobe start assertion
		al = 5'h00;
		u_ctl.cmd(4'h7, 4'h4, 14'h0000);
		u_ctl.idle(3);
		rd_lat(n_off);
		// Two cycles less additive latency, one less for DLL off
		cmp_val(n_off + 5'h03, n_on);
		u_ctl.idle(4);
		u_ctl.cmd(4'ha, 4'h4, 14'h0400);
		u_ctl.idle(8);
		u_ctl.set_cke(1'b0, 1'b1, 4'h0);
		cmp_state(sdpsd_pkg::ST_PD_PRE);
		u_ctl.set_cke(1'b1, 1'b1, 4'h0);
		cmp_state(sdpsd_pkg::ST_IDLE);
		u_ctl.on_die_termination(1'b1);
		u_ctl.idle(4);
		cmp_state(sdpsd_pkg::ST_IDLE);
		cmp_val({4'h0, term}, 5'h01);
		u_ctl.set_cke(1'b0, 1'b0, 4'h9);
		cmp_state(sdpsd_pkg::ST_SELF_REF);
		cmp_val({4'h0, term}, 5'h00);
		u_ctl.cmd(4'h8, 4'h1, 14'h0001);
		u_ctl.idle(4);
		cmp_val({4'h0, dll}, 5'h00);
		cmp_state(sdpsd_pkg::ST_SELF_REF);
		u_ctl.set_cke(1'b1, 1'b1, 4'h0);
		cmp_state(sdpsd_pkg::ST_IDLE);
		u_ctl.on_die_termination(1'b0);
		u_ctl.cmd(4'h8, 4'h1, 14'h0001);
		u_ctl.idle(4);
		cmp_val({4'h0, dll}, 5'h01);
		u_ctl.cmd(4'h7, 4'h4, 14'h0000);
		u_ctl.idle(3);
		u_ctl.set_cke(1'b0, 1'b0, 4'h9);
		cmp_val({4'h0, state === 4'(sdpsd_pkg::ST_SELF_REF)}, 5'h00);
		end_sim();
	end
endmodule
